// ==== dv/psovp_ctrl_assertions.sv ====
// checker: mode and overvoltage relations at the control block ports
// assumes bind into psovp_ctrl, one clock domain
`timescale 1ns/1ps
module psovp_ctrl_assertions #(parameter int unsigned NUM_PHASES = 4) (
  input wire logic i_ref_clk, i_arst_n, i_enable, i_power_save_request,
  input wire logic i_auto_power_save_enable, i_sample_tick, i_diff_sense_over,
  input wire logic [2:0] i_phase_count,
  input logic [2*NUM_PHASES-1:0] o_phase_mod,
  input logic [NUM_PHASES-1:0] o_low_side_on,
  input logic o_regulator_ready, o_overvoltage_fault, o_power_save_active,
  input logic [2:0] o_active_phases
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // tripped picture: fault set, ready low, every low side on
  sequence s_trip; o_overvoltage_fault && !o_regulator_ready && &o_low_side_on; endsequence
  property p_enter; $fell(i_power_save_request) && o_regulator_ready |-> ##2 o_power_save_active; endproperty
  a_enter: assert property (p_enter) else $error("request low did not enter saving");
  property p_one; o_power_save_active |-> o_active_phases == 3'h1; endproperty
  a_one: assert property (p_one) else $error("saving with more than one phase");
  // a trip overrides the parked lanes, so only a clean saving state is checked
  property p_shed;
    o_power_save_active && !o_overvoltage_fault |-> o_phase_mod[2*NUM_PHASES-1:2] == {(NUM_PHASES-1){2'h2}};
  endproperty
  a_shed: assert property (p_shed) else $error("shed lane not mid-level");
  property p_back;
    $rose(i_power_save_request) && o_power_save_active && !i_auto_power_save_enable
      |-> ##2 o_active_phases == i_phase_count;
  endproperty
  a_back: assert property (p_back) else $error("phase count not restored");
  property p_trip; i_sample_tick && i_diff_sense_over && o_regulator_ready |-> ##2 s_trip; endproperty
  a_trip: assert property (p_trip) else $error("overvoltage event did not trip");
  property p_hold; o_overvoltage_fault |=> s_trip; endproperty
  a_hold: assert property (p_hold) else $error("fault released without lockout");
  property p_off; (!i_enable && !o_overvoltage_fault) [*3] |=> !o_overvoltage_fault; endproperty
  a_off: assert property (p_off) else $error("trip while disabled");
  property p_code; (o_phase_mod & (o_phase_mod >> 1) & {NUM_PHASES{2'h1}}) == '0; endproperty
  a_code: assert property (p_code) else $error("illegal lane code");
endmodule

// ==== dv/psovp_ctrl_tb.sv ====
// testbench: mode rows, overvoltage trip, latch and lockout clearing
// assumes package, design, partner and checker compiled first
`timescale 1ns/1ps
module psovp_ctrl_tb;
  import psovp_pkg::*;
  logic i_ref_clk = 0, i_arst_n = 0, i_clk_en = 1, i_enable = 0, i_soft_start = 0, sleep = 0;
  logic i_power_save_request, i_auto_power_save_enable = 0, i_sample_tick = 0, i_diff_sense_over = 0;
  logic [7:0] i_voltage_id_lines = 0, i_low_power_vid = 8'h10, o_phase_mod;
  logic [3:0] i_phase_pwm = 0, o_low_side_on;
  logic [2:0] i_phase_count = 3'h3, o_active_phases;
  logic o_regulator_ready, o_overvoltage_fault, o_power_save_active;
  int err_count = 0, n_compared = 0;
  // sleep, auto, vid is low code, pwm level; expected ready, save, phases, lane 0
  logic [15:0] rows [7] = '{16'h104D, 16'h9065, 16'h8064, 16'h004C, 16'h504D, 16'h7065, 16'h504D};
  psovp_ctrl uut (.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_clk_en(i_clk_en), .i_enable(i_enable),
    .i_soft_start(i_soft_start), .i_power_save_request(i_power_save_request),
    .i_auto_power_save_enable(i_auto_power_save_enable), .i_voltage_id_lines(i_voltage_id_lines),
    .i_low_power_vid(i_low_power_vid), .i_phase_count(i_phase_count), .i_sample_tick(i_sample_tick),
    .i_diff_sense_over(i_diff_sense_over), .i_phase_pwm(i_phase_pwm), .o_phase_mod(o_phase_mod),
    .o_low_side_on(o_low_side_on), .o_regulator_ready(o_regulator_ready),
    .o_overvoltage_fault(o_overvoltage_fault), .o_power_save_active(o_power_save_active),
    .o_active_phases(o_active_phases));
  psovp_partner cpu (.i_ref_clk(i_ref_clk), .i_sleep(sleep), .o_power_save_request(i_power_save_request),
    .o_normal_state());
  // clock and watchdog
  initial forever #50 i_ref_clk = ~i_ref_clk;
  initial begin
    #1ms;
    err_count++;
    stop_test();
  end
  task automatic step(int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  task automatic chk(logic [19:0] s, logic [19:0] e);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one sample strobe, then let the trip reach the outputs
  task automatic pulse(logic ov);
    i_diff_sense_over = ov;
    i_sample_tick = 1;
    step(1);
    i_sample_tick = 0;
    step(3);
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // main sequence
  initial begin
    step(16);
    chk({o_phase_mod, o_low_side_on, o_regulator_ready, o_overvoltage_fault, o_power_save_active,
      o_active_phases}, 18'h2A804);
    i_arst_n = 1;
    pulse(1);
    chk(o_overvoltage_fault, 0);
    $display("reset and disabled watch done");
    i_enable = 1;
    i_soft_start = 1;
    step(4);
    for (int k = 0; k < 7; k++) begin
      {sleep, i_auto_power_save_enable} = rows[k][15:14];
      i_voltage_id_lines = rows[k][13] ? i_low_power_vid : 8'h00;
      i_phase_pwm = {4{rows[k][12]}};
      step(6);
      chk({o_regulator_ready, o_power_save_active, o_active_phases, o_phase_mod[1:0]}, rows[k][6:0]);
    end
    $display("mode rows done");
    pulse(1);
    chk({o_overvoltage_fault, o_regulator_ready, o_low_side_on, o_phase_mod}, 14'h2F00);
    repeat (7) pulse(1);
    i_phase_pwm = 4'h0;
    i_enable = 0;
    sleep = 1;
    pulse(0);
    chk({o_overvoltage_fault, o_regulator_ready, o_low_side_on, o_phase_mod}, 14'h2F00);
    i_arst_n = 0;
    step(2);
    i_arst_n = 1;
    step(2);
    chk(o_overvoltage_fault, 0);
    $display("overvoltage latch done");
    stop_test();
  end
endmodule
bind psovp_ctrl psovp_ctrl_assertions #(.NUM_PHASES(NUM_PHASES)) u_chk (.*);

// ==== dv/psovp_partner.sv ====
// partner: processor power-state side driving the save request
// assumes the bench asks for sleep or wake on i_sleep
`timescale 1ns/1ps
module psovp_partner import psovp_pkg::*; (
  input wire logic i_ref_clk,
  input wire logic i_sleep,
  output logic o_power_save_request = 1'b1,
  output logic o_normal_state = 1'b0
);
  int unsigned lead_q = 0;
  // request drops at once; normal state only after the release lead
  always @(negedge i_ref_clk) begin
    o_power_save_request <= !i_sleep;
    lead_q <= i_sleep ? 0 : (lead_q < PSOVP_PSR_LEAD_CYC ? lead_q + 1 : lead_q);
    o_normal_state <= !i_sleep && lead_q >= PSOVP_PSR_LEAD_CYC;
  end
endmodule

// ==== logic/psovp_ctrl.sv ====
// psovp_ctrl: power-save phase shedding and latched overvoltage supervision
// assumes inputs synchronous to i_ref_clk; i_arst_n comes from supply lockout
`timescale 1ns/1ps
// Function
// RL1: request low selects single phase saving
// RL2: processor releases request 1 us early
// RL3: saving leaves exactly one phase active
// RL4: phase one switches, others held mid-level
// RL5: request high restores configured phase count
// RL6: auto mode follows voltage id transitions
// RL7: overvoltage watch active from soft-start only
// RL8: trip forces low-sides on, ready low
// RL9: latched fault cleared only by lockout reset
// RL10: overvoltage compare event pulls ready low
// RL11: eight consecutive events latch phase outputs
// RL12: clean sample clears count; three-level encoding
module psovp_ctrl #(
  parameter int unsigned NUM_PHASES = psovp_pkg::PSOVP_NUM_PHASES,
  parameter int unsigned VID_W = 8
) (
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic i_enable,
  input wire logic i_soft_start,
  input wire logic i_power_save_request,
  input wire logic i_auto_power_save_enable,
  input wire logic [VID_W-1:0] i_voltage_id_lines,
  input wire logic [VID_W-1:0] i_low_power_vid,
  input wire logic [2:0] i_phase_count,
  input wire logic i_sample_tick,
  input wire logic i_diff_sense_over,
  input wire logic [NUM_PHASES-1:0] i_phase_pwm,
  output logic [2*NUM_PHASES-1:0] o_phase_mod,
  output logic [NUM_PHASES-1:0] o_low_side_on,
  output logic o_regulator_ready,
  output logic o_overvoltage_fault,
  output logic o_power_save_active,
  output logic [2:0] o_active_phases
);
  import psovp_pkg::*;

  psovp_state_t state_q, state_d;
  logic [3:0] ov_cnt_q;
  logic ov_trip_q;
  logic latched_q;
  logic auto_save_q;
  logic [VID_W-1:0] vid_q;
  logic [2:0] saved_phases_q;
  // combinational mode helpers
  logic save_req;
  logic ov_watch;

  // phase encoding helper used for every output lane
  function automatic logic [1:0] psovp_enc(input logic en, input logic pwm);
    if (!en) begin
      psovp_enc = PSOVP_PH_MID;
    end else if (pwm) begin
      psovp_enc = PSOVP_PH_HIGH;
    end else begin
      psovp_enc = PSOVP_PH_LOW;
    end
  endfunction

  // saving wanted: pin low, or auto mode after a move to the low-power vid
  assign save_req = !i_power_save_request || (i_auto_power_save_enable && auto_save_q); // RL1
  // watch only while enabled and from soft-start on
  assign ov_watch = i_enable && (i_soft_start || state_q != PSOVP_ST_OFF); // RL7

  // auto mode tracks voltage id transitions
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vid_q <= '0;
      auto_save_q <= 1'b0;
    end else if (i_clk_en) begin
      vid_q <= i_voltage_id_lines;
      if (i_auto_power_save_enable && i_power_save_request && vid_q != i_voltage_id_lines) begin
        auto_save_q <= (i_voltage_id_lines == i_low_power_vid); // RL6
      end else if (!i_auto_power_save_enable) begin
        auto_save_q <= 1'b0;
      end
    end
  end

  // consecutive overvoltage counter and trip flag
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ov_cnt_q <= PSOVP_OV_COUNT_RESET;
      ov_trip_q <= 1'b0;
      latched_q <= 1'b0;
    end else if (i_clk_en) begin
      if (ov_watch && i_sample_tick) begin
        if (i_diff_sense_over) begin
          ov_trip_q <= 1'b1; // RL10
          if (ov_cnt_q < PSOVP_OV_LATCH_COUNT) begin
            ov_cnt_q <= ov_cnt_q + 4'h1;
          end
          if (ov_cnt_q + 4'h1 >= PSOVP_OV_LATCH_COUNT) begin
            latched_q <= 1'b1; // RL11
          end
        end else if (!latched_q) begin
          ov_cnt_q <= PSOVP_OV_COUNT_RESET; // RL12
        end
      end
      // latch held; only the lockout reset clears it
    end
  end

  // remember configured phase count outside saving
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      saved_phases_q <= PSOVP_DEF_PHASES;
    end else if (i_clk_en && state_q != PSOVP_ST_SAVE) begin
      saved_phases_q <= i_phase_count;
    end
  end

  // mode selection
  always_comb begin
    state_d = state_q;
    case (state_q)
      PSOVP_ST_OFF: begin
        if (i_enable && i_soft_start) begin
          state_d = PSOVP_ST_RUN;
        end
      end
      PSOVP_ST_RUN: begin
        if (save_req) begin
          state_d = PSOVP_ST_SAVE; // RL3
        end
      end
      PSOVP_ST_SAVE: begin
        if (!save_req) begin
          state_d = PSOVP_ST_RUN; // RL5
        end
      end
      default: begin
        state_d = PSOVP_ST_FAULT;
      end
    endcase
    if (state_q != PSOVP_ST_FAULT && !i_enable) begin
      state_d = PSOVP_ST_OFF;
    end
    if (ov_trip_q) begin
      state_d = PSOVP_ST_FAULT; // RL9
    end
  end

  // mode register, frozen while the clock enable is low
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= PSOVP_ST_OFF;
    end else if (i_clk_en) begin
      state_q <= state_d;
    end
  end

  // regulating modes: phases switching and ready allowed
  function automatic logic psovp_in_service(input psovp_state_t st);
    psovp_in_service = (st == PSOVP_ST_RUN) || (st == PSOVP_ST_SAVE);
  endfunction

  // single-phase saving mode
  function automatic logic psovp_is_save(input psovp_state_t st);
    psovp_is_save = (st == PSOVP_ST_SAVE);
  endfunction

  // lane drive, computed before the output flops
  logic force_low;
  logic [2:0] lane_limit;
  logic [2*NUM_PHASES-1:0] phase_mod_d;
  logic [NUM_PHASES-1:0] low_side_d;

  // trip, fault state or latch pull every lane low with its low side on
  assign force_low = latched_q || ov_trip_q || (state_q == PSOVP_ST_FAULT); // RL8 RL11

  // number of lanes that follow their modulator in the present mode
  always_comb begin
    lane_limit = '0;
    if (psovp_is_save(state_q)) begin
      lane_limit = PSOVP_ONE_PHASE; // RL3
    end else if (state_q == PSOVP_ST_RUN) begin
      lane_limit = saved_phases_q; // RL5
    end
  end

  // per-lane code: enabled lanes switch low/high, shed lanes park mid-level
  for (genvar g = 0; g < NUM_PHASES; g++) begin : g_lane
    assign phase_mod_d[2*g +: 2] = force_low ? PSOVP_PH_LOW : psovp_enc(g < int'(lane_limit), i_phase_pwm[g]); // RL4 RL12
    assign low_side_d[g] = force_low; // RL8
  end

  // registered lane codes and low-side commands
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_phase_mod <= {NUM_PHASES{PSOVP_PH_MID}};
      o_low_side_on <= '0;
    end else if (i_clk_en) begin
      o_phase_mod <= phase_mod_d; // RL11
      o_low_side_on <= low_side_d;
    end
  end

  // registered fault and ready status
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_regulator_ready <= 1'h0;
      o_overvoltage_fault <= 1'h0;
    end else if (i_clk_en) begin
      o_overvoltage_fault <= ov_trip_q;
      o_regulator_ready <= psovp_in_service(state_q) && !ov_trip_q; // RL8
    end
  end

  // registered saving flag and active phase count
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_power_save_active <= 1'h0;
      o_active_phases <= PSOVP_DEF_PHASES;
    end else if (i_clk_en) begin
      o_power_save_active <= psovp_is_save(state_q);
      o_active_phases <= psovp_is_save(state_q) ? PSOVP_ONE_PHASE : saved_phases_q;
    end
  end
endmodule

// ==== logic/psovp_pkg.sv ====
// psovp_pkg: shared constants and types for the phase shed and overvoltage control block
// assumes a single 10 MHz reference clock and plain port control bits
package psovp_pkg;
  // number of phases the controller can drive
  localparam int unsigned PSOVP_NUM_PHASES = 4;
  // phase output encoding: two bits per phase
  typedef enum logic [1:0] {
    PSOVP_PH_LOW  = 2'h0,
    PSOVP_PH_HIGH = 2'h1,
    PSOVP_PH_MID  = 2'h2
  } psovp_phase_t;
  // controller modes, one-hot
  typedef enum logic [3:0] {
    PSOVP_ST_OFF   = 4'h1,
    PSOVP_ST_RUN   = 4'h2,
    PSOVP_ST_SAVE  = 4'h4,
    PSOVP_ST_FAULT = 4'h8
  } psovp_state_t;
  // consecutive overvoltage events before latching all phase outputs
  localparam logic [3:0] PSOVP_OV_LATCH_COUNT = 4'h8;
  localparam logic [3:0] PSOVP_OV_COUNT_RESET = 4'h0;
  // release lead time of the power-save request (other party), in ns
  localparam int unsigned PSOVP_PSR_LEAD_NS = 1000;
  localparam int unsigned PSOVP_CLK_PERIOD_NS = 100;
  localparam int unsigned PSOVP_PSR_LEAD_CYC = (PSOVP_PSR_LEAD_NS + PSOVP_CLK_PERIOD_NS - 1) / PSOVP_CLK_PERIOD_NS;
  // default configured phase count
  localparam logic [2:0] PSOVP_DEF_PHASES = 3'h4;
  localparam logic [2:0] PSOVP_ONE_PHASE = 3'h1;
endpackage
